/* File: inc/psc_pkg.sv */
package psc_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_SW_A      = 8'h00;
	localparam logic [7:0] ADDR_SW_B      = 8'h04;
	localparam logic [7:0] ADDR_SW_C      = 8'h08;
	localparam logic [7:0] ADDR_SW_D      = 8'h0C;
	localparam logic [7:0] ADDR_EN_DEB    = 8'h10;
	localparam logic [7:0] ADDR_CAP_SEL   = 8'h14;
	localparam logic [7:0] ADDR_STATUS    = 8'h18;

	// Field layout of the enable/debounce register
	localparam int EN_AMP2_BIT   = 7;
	localparam int EN_AMP1_BIT   = 6;
	localparam int EN_CMP_BIT    = 5;
	localparam int DEB_LSB       = 0;
	localparam int DEB_W         = 3;

	// Writable masks; everything else reads zero
	localparam logic [7:0] SW_FULL_MASK = 8'hFF;
	localparam logic [7:0] SW_D_MASK    = 8'h03;
	localparam logic [7:0] EN_DEB_MASK  = 8'hE7;
	localparam logic [7:0] CAP_SEL_MASK = 8'h03;
	localparam logic [7:0] REG_RESET    = 8'h00;

	// Capture source codes
	localparam logic [1:0] CAP_FROM_PIN      = 2'h0;
	localparam logic [1:0] CAP_FROM_DECISION = 2'h1;

	// Debounce counter width: longest code 7 needs 128 cycles
	localparam int DEB_CNT_W = 8;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [7:0] sw_a;
		logic [7:0] sw_b;
		logic [7:0] sw_c;
		logic [7:0] sw_d;
		logic [7:0] en_deb;
		logic [7:0] cap_sel;
	} psc_regs_type;

	typedef struct packed {
		logic       amp_stage2_enable;
		logic       amp_stage1_enable;
		logic       comparator_dac_enable;
		logic [25:0] analog_switch_bits;
	} psc_analog_ctrl_type;

endpackage

/* File: design/psc_debounce.sv */
`timescale 1ns/1ps
module psc_debounce #(
	parameter int CNT_W = psc_pkg::DEB_CNT_W
) (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Control
	input  wire logic             enable,
	input  wire logic [2:0]       debounce_select,
	// Data
	input  wire logic             sample_in,
	output logic                  decision_out
);

	// Code 7 needs a count of 128
	if (CNT_W < 8) begin : g_cnt_w_check
		$error("psc_debounce: CNT_W too small for code 7");
	end

	typedef struct packed {
		logic             candidate;
		logic [CNT_W-1:0] count;
		logic             decision;
	} psc_deb_state_type;

	psc_deb_state_type state;
	psc_deb_state_type next_state;
	logic [CNT_W-1:0]  target;

	// Stable for 2^n samples: counting from change gives 2^n-1..2^n periods
	assign target = CNT_W'(1) << debounce_select;

	always_comb begin
		next_state = state;
		if (!enable) begin
			next_state = '0;
		end else if (debounce_select == 3'h0) begin
			next_state.candidate = sample_in;
			next_state.count     = '0;
			next_state.decision  = sample_in;
		end else if (sample_in != state.candidate) begin
			next_state.candidate = sample_in;
			next_state.count     = CNT_W'(1);
		end else if (state.count < target) begin
			next_state.count = state.count + CNT_W'(1);
			if (state.count + CNT_W'(1) == target) begin
				next_state.decision = state.candidate;
			end
		end else begin
			next_state.decision = state.candidate;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign decision_out = state.decision;

endmodule

/* File: design/psc_top.sv */
// Notes on behaviour
// - Twenty-six switch bits close on 1, open on 0, read back as written.
// - Fourth switch register keeps bits 1..0 only; bits 7..2 read zero.
// - Enable/debounce bits 4 and 3 read zero whatever is written.
// - Enable bit 7 drives the second-stage amplifier enable.
// - Enable bit 6 drives the first-stage amplifier enable.
// - Enable bit 5 enables comparator and reference DAC together.
// - Debounce code 0 bypasses; code n needs 2^n-1 to 2^n stable cycles.
// - Filtered decision drives an interrupt request toward the processor.
// - Capture source select may route the decision to the third timer capture.
// - Comparator disabled forces its status bit and the decision to zero.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module psc_top (
	// Clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// AXI4-Lite write address
	input  wire logic [7:0]                  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]                  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// Analog cells
	input  wire logic                        comparator_raw,
	output psc_pkg::psc_analog_ctrl_type     analog_ctrl,
	// Interrupt and timer
	output logic                             proximity_irq,
	input  wire logic                        capture_pin,
	output logic                             timer_capture_input
);

	typedef struct packed {
		psc_pkg::psc_regs_type regs;
		logic                  aw_held;
		logic [7:0]            aw_addr;
		logic                  w_held;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [1:0]            rresp;
		logic [31:0]           rdata;
		logic                  cmp_meta;
		logic                  cmp_sync;
		logic                  pin_meta;
		logic                  pin_sync;
		logic                  capture;
		logic                  cmp_status;
	} psc_top_state_type;

	psc_top_state_type state;
	psc_top_state_type next_state;
	logic              proximity_decision;
	logic              comparator_on;
	logic              do_write;

	function automatic logic addr_mapped(input logic [7:0] a);
		if (a == psc_pkg::ADDR_SW_A) return 1'b1;
		else if (a == psc_pkg::ADDR_SW_B) return 1'b1;
		else if (a == psc_pkg::ADDR_SW_C) return 1'b1;
		else if (a == psc_pkg::ADDR_SW_D) return 1'b1;
		else if (a == psc_pkg::ADDR_EN_DEB) return 1'b1;
		else if (a == psc_pkg::ADDR_CAP_SEL) return 1'b1;
		else if (a == psc_pkg::ADDR_STATUS) return 1'b1;
		else return 1'b0;
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] d,
		input logic [3:0] strb, input logic [7:0] mask);
		return strb[0] ? (d[7:0] & mask) : old;
	endfunction

	assign comparator_on = state.regs.en_deb[psc_pkg::EN_CMP_BIT];
	assign do_write      = state.aw_held && state.w_held && !state.bvalid;

	always_comb begin
		next_state = state;
		// Two-stage synchronisers for asynchronous inputs
		next_state.cmp_meta = comparator_raw;
		next_state.cmp_sync = state.cmp_meta;
		next_state.pin_meta = capture_pin;
		next_state.pin_sync = state.pin_meta;
		next_state.cmp_status = comparator_on & state.cmp_sync;
		// Capture routing
		if (state.regs.cap_sel[1:0] == psc_pkg::CAP_FROM_DECISION) begin
			next_state.capture = proximity_decision;
		end else begin
			next_state.capture = state.pin_sync;
		end
		// Write channel
		if (s_axi_awvalid && !state.aw_held) begin
			next_state.aw_held = 1'b1;
			next_state.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !state.w_held) begin
			next_state.w_held = 1'b1;
			next_state.w_data = s_axi_wdata;
			next_state.w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			next_state.aw_held = 1'b0;
			next_state.w_held  = 1'b0;
			next_state.bvalid  = 1'b1;
			next_state.bresp   = addr_mapped(state.aw_addr) ? psc_pkg::RESP_OKAY
				: psc_pkg::RESP_SLVERR;
			if (state.aw_addr == psc_pkg::ADDR_SW_A) begin
				next_state.regs.sw_a = merge(state.regs.sw_a, state.w_data, state.w_strb,
					psc_pkg::SW_FULL_MASK);
			end else if (state.aw_addr == psc_pkg::ADDR_SW_B) begin
				next_state.regs.sw_b = merge(state.regs.sw_b, state.w_data, state.w_strb,
					psc_pkg::SW_FULL_MASK);
			end else if (state.aw_addr == psc_pkg::ADDR_SW_C) begin
				next_state.regs.sw_c = merge(state.regs.sw_c, state.w_data, state.w_strb,
					psc_pkg::SW_FULL_MASK);
			end else if (state.aw_addr == psc_pkg::ADDR_SW_D) begin
				next_state.regs.sw_d = merge(state.regs.sw_d, state.w_data, state.w_strb,
					psc_pkg::SW_D_MASK);
			end else if (state.aw_addr == psc_pkg::ADDR_EN_DEB) begin
				next_state.regs.en_deb = merge(state.regs.en_deb, state.w_data,
					state.w_strb, psc_pkg::EN_DEB_MASK);
			end else if (state.aw_addr == psc_pkg::ADDR_CAP_SEL) begin
				next_state.regs.cap_sel = merge(state.regs.cap_sel, state.w_data,
					state.w_strb, psc_pkg::CAP_SEL_MASK);
			end
		end
		if (state.bvalid && s_axi_bready) begin
			next_state.bvalid = 1'b0;
		end
		// Read channel
		if (s_axi_arvalid && !state.rvalid) begin
			next_state.rvalid = 1'b1;
			next_state.rresp  = addr_mapped(s_axi_araddr) ? psc_pkg::RESP_OKAY
				: psc_pkg::RESP_SLVERR;
			next_state.rdata  = 32'h0000_0000;
			if (s_axi_araddr == psc_pkg::ADDR_SW_A) begin
				next_state.rdata[7:0] = state.regs.sw_a;
			end else if (s_axi_araddr == psc_pkg::ADDR_SW_B) begin
				next_state.rdata[7:0] = state.regs.sw_b;
			end else if (s_axi_araddr == psc_pkg::ADDR_SW_C) begin
				next_state.rdata[7:0] = state.regs.sw_c;
			end else if (s_axi_araddr == psc_pkg::ADDR_SW_D) begin
				next_state.rdata[7:0] = state.regs.sw_d;
			end else if (s_axi_araddr == psc_pkg::ADDR_EN_DEB) begin
				next_state.rdata[7:0] = state.regs.en_deb;
			end else if (s_axi_araddr == psc_pkg::ADDR_CAP_SEL) begin
				next_state.rdata[7:0] = state.regs.cap_sel;
			end else if (s_axi_araddr == psc_pkg::ADDR_STATUS) begin
				next_state.rdata[1:0] = {proximity_decision, state.cmp_status};
			end
		end else if (state.rvalid && s_axi_rready) begin
			next_state.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	psc_debounce #(
		.CNT_W(psc_pkg::DEB_CNT_W)
	) i_psc_debounce (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.enable         (comparator_on),
		.debounce_select(state.regs.en_deb[psc_pkg::DEB_LSB +: psc_pkg::DEB_W]),
		.sample_in      (state.cmp_status),
		.decision_out   (proximity_decision)
	);

	assign s_axi_awready = !state.aw_held;
	assign s_axi_wready  = !state.w_held;
	assign s_axi_bvalid  = state.bvalid;
	assign s_axi_bresp   = state.bresp;
	assign s_axi_arready = !state.rvalid;
	assign s_axi_rvalid  = state.rvalid;
	assign s_axi_rresp   = state.rresp;
	assign s_axi_rdata   = state.rdata;

	assign analog_ctrl.analog_switch_bits = {state.regs.sw_d[1:0], state.regs.sw_c,
		state.regs.sw_b, state.regs.sw_a};
	assign analog_ctrl.amp_stage2_enable     = state.regs.en_deb[psc_pkg::EN_AMP2_BIT];
	assign analog_ctrl.amp_stage1_enable     = state.regs.en_deb[psc_pkg::EN_AMP1_BIT];
	assign analog_ctrl.comparator_dac_enable = comparator_on;
	assign proximity_irq       = proximity_decision;
	assign timer_capture_input = state.capture;

	a_sw_d_upper: assert property (@(posedge aclk) disable iff (!aresetn)
		state.regs.sw_d[7:2] == 6'h00) else $error("upper switch bits set");
	a_en_unimpl: assert property (@(posedge aclk) disable iff (!aresetn)
		state.regs.en_deb[4:3] == 2'h0) else $error("unimplemented bits set");
	a_cmp_off_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		!comparator_on |=> !state.cmp_status) else $error("status not zero");
	a_dec_off_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		!comparator_on |=> !proximity_decision) else $error("decision not zero");
	a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		proximity_irq == proximity_decision) else $error("irq mismatch");
	a_cap_route: assert property (@(posedge aclk) disable iff (!aresetn)
		state.regs.cap_sel[1:0] == psc_pkg::CAP_FROM_DECISION && $stable(state.regs.cap_sel)
		|=> timer_capture_input == $past(proximity_decision))
		else $error("capture route wrong");
	a_amp_enables: assert property (@(posedge aclk) disable iff (!aresetn)
		analog_ctrl.amp_stage2_enable == state.regs.en_deb[7]
		&& analog_ctrl.amp_stage1_enable == state.regs.en_deb[6])
		else $error("amp enable wrong");
	a_write_sw_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && state.aw_addr == psc_pkg::ADDR_SW_A && state.w_strb[0]
		|=> analog_ctrl.analog_switch_bits[7:0] == $past(state.w_data[7:0]))
		else $error("switch write lost");
	a_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
		comparator_on && state.regs.en_deb[2:0] == 3'h0 && $stable(state.regs.en_deb)
		|=> proximity_decision == $past(state.cmp_status)) else $error("bypass wrong");
	a_bresp_after: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write |=> s_axi_bvalid) else $error("no write response");
	a_reset_clear: assert property (@(posedge aclk)
		!aresetn |=> state.regs == '0 && !state.bvalid && !state.rvalid)
		else $error("reset left state");
	a_cmp_dac: assert property (@(posedge aclk) disable iff (!aresetn)
		analog_ctrl.comparator_dac_enable == state.regs.en_deb[5])
		else $error("comparator enable wrong");
	a_hold_count: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(state.cmp_status) && state.regs.en_deb[2:0] == 3'h2
		&& comparator_on ##1 1 |-> $stable(proximity_decision))
		else $error("decision moved early");

	c_write: cover property (@(posedge aclk) do_write);
	c_read: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
	c_irq: cover property (@(posedge aclk) $rose(proximity_irq));
	c_capture: cover property (@(posedge aclk) $rose(timer_capture_input));

endmodule

/* File: verif/psc_analog_model.sv */
`timescale 1ns/1ps
module psc_analog_model (
	// Clock
	input  wire logic                         aclk,
	// Control and stimulus
	input  wire psc_pkg::psc_analog_ctrl_type analog_ctrl,
	input  wire logic                         sense_level,
	// Comparator output
	output logic                              comparator_raw
);
	logic flip = 1'b0;
	// A disabled comparator output cannot be trusted, so it wanders
	always @(posedge aclk) begin
		flip <= !flip;
	end
	assign comparator_raw = analog_ctrl.comparator_dac_enable ? sense_level : flip;
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic                         aclk = 1'b0;
	logic                         aresetn = 1'b0;
	logic [7:0]                   s_axi_awaddr = 8'h00;
	logic                         s_axi_awvalid = 1'b0;
	logic                         s_axi_awready;
	logic [31:0]                  s_axi_wdata = 32'h00000000;
	logic [3:0]                   s_axi_wstrb = 4'h0;
	logic                         s_axi_wvalid = 1'b0;
	logic                         s_axi_wready;
	logic [1:0]                   s_axi_bresp;
	logic                         s_axi_bvalid;
	logic                         s_axi_bready = 1'b0;
	logic [7:0]                   s_axi_araddr = 8'h00;
	logic                         s_axi_arvalid = 1'b0;
	logic                         s_axi_arready;
	logic [31:0]                  s_axi_rdata;
	logic [1:0]                   s_axi_rresp;
	logic                         s_axi_rvalid;
	logic                         s_axi_rready = 1'b0;
	logic                         comparator_raw;
	logic                         sense_level = 1'b0;
	logic                         capture_pin = 1'b0;
	logic                         proximity_irq;
	logic                         timer_capture_input;
	psc_pkg::psc_analog_ctrl_type analog_ctrl;
	int                           err_total = 0;
	int                           n_checks = 0;
	int                           cnt;
	logic [7:0]                   v;
	logic                         seen;
	logic [3:0]                   wr_strb = 4'hF;
	logic [7:0]                   pat [3] = '{8'hFF, 8'h5A, 8'h00};
	logic [7:0]                   enp [5] = '{8'h80, 8'h40, 8'h20, 8'hFF, 8'h18};

	psc_top i_psc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comparator_raw, .analog_ctrl,
		.proximity_irq, .capture_pin, .timer_capture_input);
	psc_analog_model i_psc_analog_model (.aclk, .analog_ctrl, .sense_level, .comparator_raw);

	initial begin
		forever #2.5 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic hang();
		chk(32'h0, 32'h1);
		close_out();
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= wr_strb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		if (i == 64) hang();
		chk(s_axi_bresp, er);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		if (i == 64) hang();
		chk(s_axi_rdata, {24'h000000, ed});
		chk(s_axi_rresp, er);
		s_axi_rready <= 1'b0;
	endtask
	// Sel 1 watches the capture output, 0 the interrupt
	task automatic wait_for(input logic sel, input logic lvl, output int c);
		c = 0;
		while (((sel ? timer_capture_input : proximity_irq) !== lvl) && c < 400) begin
			@(posedge aclk);
			c++;
		end
		if (c == 400) hang();
	endtask
	task automatic watch_irq(output logic s);
		s = 1'b0;
		repeat (30) begin
			@(posedge aclk);
			s = s | (proximity_irq !== 1'b0);
		end
	endtask
	// Spare edges let a freshly enabled comparator flush stale samples
	task automatic rise(input logic lvl);
		repeat (5) @(posedge aclk);
		sense_level <= lvl;
	endtask

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rdc(8'(i * 4), 8'h00, 2'h0);
		end
		chk(analog_ctrl, 32'h0);
		$display("test reset done");
		foreach (pat[k]) begin
			v = pat[k];
			for (int i = 0; i < 4; i++) begin
				wr(8'(i * 4), v, 2'h0);
			end
			for (int i = 0; i < 3; i++) begin
				rdc(8'(i * 4), v, 2'h0);
			end
			rdc(psc_pkg::ADDR_SW_D, v & 8'h03, 2'h0);
			chk(analog_ctrl.analog_switch_bits, {v[1:0], v, v, v});
		end
		wr_strb = 4'hE;
		wr(psc_pkg::ADDR_SW_A, 8'hAA, 2'h0);
		rdc(psc_pkg::ADDR_SW_A, 8'h00, 2'h0);
		wr_strb = 4'hF;
		$display("test switches done");
		foreach (enp[k]) begin
			v = enp[k];
			wr(psc_pkg::ADDR_EN_DEB, v, 2'h0);
			rdc(psc_pkg::ADDR_EN_DEB, v & 8'hE7, 2'h0);
			chk(analog_ctrl.amp_stage2_enable, v[7]);
			chk(analog_ctrl.amp_stage1_enable, v[6]);
			chk(analog_ctrl.comparator_dac_enable, v[5]);
		end
		wr(8'h1C, 8'hFF, psc_pkg::RESP_SLVERR);
		rdc(8'h1C, 8'h00, psc_pkg::RESP_SLVERR);
		$display("test enables done");
		wr(psc_pkg::ADDR_CAP_SEL, 8'h01, 2'h0);
		for (int n = 0; n < 8; n++) begin
			wr(psc_pkg::ADDR_EN_DEB, 8'h20 | 8'(n), 2'h0);
			rise(1'b1);
			wait_for(1'b0, 1'b1, cnt);
			chk(cnt >= (1 << n) - 1 && cnt <= (1 << n) + 6, 1'b1);
			rdc(psc_pkg::ADDR_STATUS, 8'h03, 2'h0);
			chk(timer_capture_input, 1'b1);
			rise(1'b0);
			wait_for(1'b0, 1'b0, cnt);
			chk(cnt >= (1 << n) - 1 && cnt <= (1 << n) + 6, 1'b1);
		end
		wr(psc_pkg::ADDR_EN_DEB, 8'h23, 2'h0);
		rise(1'b1);
		repeat (3) @(posedge aclk);
		sense_level <= 1'b0;
		watch_irq(seen);
		chk(seen, 1'b0);
		$display("test debounce done");
		wr(psc_pkg::ADDR_EN_DEB, 8'h20, 2'h0);
		rise(1'b1);
		wait_for(1'b0, 1'b1, cnt);
		wr(psc_pkg::ADDR_EN_DEB, 8'h00, 2'h0);
		wait_for(1'b0, 1'b0, cnt);
		chk(cnt <= 6, 1'b1);
		rdc(psc_pkg::ADDR_STATUS, 8'h00, 2'h0);
		watch_irq(seen);
		chk(seen, 1'b0);
		$display("test disable done");
		wr(psc_pkg::ADDR_CAP_SEL, 8'h00, 2'h0);
		wr(psc_pkg::ADDR_EN_DEB, 8'h20, 2'h0);
		wait_for(1'b0, 1'b1, cnt);
		rdc(psc_pkg::ADDR_CAP_SEL, 8'h00, 2'h0);
		chk(timer_capture_input, 1'b0);
		capture_pin <= 1'b1;
		wait_for(1'b1, 1'b1, cnt);
		chk(cnt <= 4, 1'b1);
		capture_pin <= 1'b0;
		wait_for(1'b1, 1'b0, cnt);
		chk(cnt <= 4, 1'b1);
		$display("test capture done");
		close_out();
	end
endmodule
